// >>> hw/ibp_flags.sv
// packs the new-data and error flag bytes
`timescale 1ns/1ps
`default_nettype none
module ibp_flags
  import ibp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_sensor_new,
  input wire logic i_range_over_flag,
  input wire logic [2:0] i_delta_rotation_new,
  input wire logic [2:0] i_delta_speed_new,
  input wire logic i_all_error_flag,
  output logic [15:0] o_flag_word
);
  typedef struct packed {
    logic [15:0] flag_word;
  } ibp_flags_s;
  ibp_flags_s state_reg;
  ibp_flags_s state_next;

  // upper byte new data, lower byte error flags; bit 1 reserved as zero
  always_comb begin
    state_next = state_reg;
    state_next.flag_word[15:8] = {i_sensor_new, i_range_over_flag};
    state_next.flag_word[7:0] = {i_delta_rotation_new, i_delta_speed_new,
                                 1'b0, i_all_error_flag};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_flag_word = state_reg.flag_word;

  AST_RSV_BIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_flag_word[1] == 1'b0) else $error("reserved flag bit set");
  AST_ND_MAP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ##1 o_flag_word[15:9] == $past(i_sensor_new)) else $error("new data map wrong");
endmodule
`default_nettype wire

// >>> hw/ibp_formatter.sv
// burst packet formatter: spi word stream and uart byte stream
// What this block does
// - content F007, width 0000: spi burst of 11 words: flags, 7 upper words, then gpio,count,checksum.
// - content F007, width 7000: spi burst of 18 words, upper then lower halves.
// - uart packet F107/7100: 0x80, new-data, error flags, 32-bit values, first angle.
// - new-data byte: bit7 temp, 6..4 rate, 3..1 accel, bit0 range over.
// - error byte: 7..5 delta angle, 4..2 delta velocity, bit1 reserved, bit0 all-error.
// - every 16-bit word goes out most significant byte first.
`timescale 1ns/1ps
`default_nettype none
module ibp_formatter
  import ibp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_burst_content_select,
  input wire logic [15:0] i_burst_width_select,
  input wire logic i_spi_start,
  input wire logic i_uart_start,
  input wire ibp_sample_s i_sample,
  input wire logic [6:0] i_sensor_new,
  input wire logic i_range_over_flag,
  input wire logic [2:0] i_delta_rotation_new,
  input wire logic [2:0] i_delta_speed_new,
  input wire logic i_all_error_flag,
  input wire logic i_tx_ready,
  output logic o_spi_valid,
  output logic [15:0] o_spi_word,
  output logic o_uart_valid,
  output logic [7:0] o_uart_byte,
  output logic o_busy,
  output logic o_config_error
);
  typedef struct packed {
    ibp_state_e st;
    logic wide;
    logic [5:0] idx;
    logic lo_byte;
    ibp_sample_s smp;
    logic spi_valid;
    logic [15:0] spi_word;
    logic uart_valid;
    logic [7:0] uart_byte;
    logic cfg_err;
    logic busy;
  } ibp_fmt_s;
  ibp_fmt_s state_reg;
  ibp_fmt_s state_next;
  logic [15:0] flag_word;
  logic [15:0] cur_word;

  ibp_flags u_flags (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_sensor_new(i_sensor_new),
    .i_range_over_flag(i_range_over_flag),
    .i_delta_rotation_new(i_delta_rotation_new),
    .i_delta_speed_new(i_delta_speed_new),
    .i_all_error_flag(i_all_error_flag),
    .o_flag_word(flag_word)
  );

  // word for a 16-bit slot: field index selects value, half picks upper or lower
  function automatic logic [15:0] field_word(input ibp_sample_s s, input logic [4:0] f,
                                             input logic lower);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (f < 5'h07) begin
      v = s.sensor[f[2:0]];
    end else if (f == IBP_FLD_ANGLE) begin
      v = s.angle1;
    end
    field_word = lower ? v[15:0] : v[31:16];
  endfunction

  // spi word at position idx (position 0 is the flag word)
  function automatic logic [15:0] spi_slot(input ibp_sample_s s, input logic wide,
                                           input logic [5:0] idx, input logic [15:0] fw);
    logic [5:0] k;
    k = idx - 6'h01;
    if (idx == 6'h00) begin
      spi_slot = fw;
    end else if (!wide && idx < 6'h08) begin
      spi_slot = field_word(s, k[4:0], 1'b0);
    end else if (wide && idx < 6'h0F) begin
      spi_slot = field_word(s, {1'b0, k[4:1]}, k[0]);
    end else begin
      k = wide ? idx - 6'h0F : idx - 6'h08;
      spi_slot = (k == 6'h00) ? s.gpio : (k == 6'h01) ? s.count : s.checksum;
    end
  endfunction

  // uart 16-bit slot: 0 address, 1 flags, 2..17 value halves, 18.. trailer
  function automatic logic [15:0] uart_slot(input ibp_sample_s s, input logic [5:0] idx,
                                            input logic [15:0] fw);
    logic [5:0] k;
    k = idx - 6'h02;
    if (idx == 6'h01) begin
      uart_slot = fw;
    end else if (idx < 6'h10) begin
      uart_slot = field_word(s, {1'b0, k[4:1]}, k[0]);
    end else if (idx < 6'h12) begin
      uart_slot = field_word(s, IBP_FLD_ANGLE, idx[0]);
    end else if (idx == 6'h12) begin
      uart_slot = s.gpio;
    end else if (idx == 6'h13) begin
      uart_slot = s.count;
    end else begin
      uart_slot = s.checksum;
    end
  endfunction

  assign cur_word = (state_reg.st == IBP_UART) ?
                    uart_slot(state_reg.smp, state_reg.idx, flag_word) :
                    spi_slot(state_reg.smp, state_reg.wide, state_reg.idx, flag_word);

  // sequencer: one word or byte per accepted cycle, stalls on tx ready low
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      IBP_IDLE: begin
        state_next.spi_valid = 1'b0;
        state_next.uart_valid = 1'b0;
        state_next.idx = 6'h00;
        state_next.lo_byte = 1'b0;
        if (i_spi_start) begin
          state_next.cfg_err = !((i_burst_content_select == IBP_CONTENT_16 &&
                                  i_burst_width_select == IBP_WIDTH_16) ||
                                 (i_burst_content_select == IBP_CONTENT_32 &&
                                  i_burst_width_select == IBP_WIDTH_32));
          state_next.wide = (i_burst_width_select == IBP_WIDTH_32);
          state_next.smp = i_sample;
          state_next.st = IBP_SPI;
        end else if (i_uart_start) begin
          state_next.cfg_err = !(i_burst_content_select == IBP_CONTENT_UART &&
                                 i_burst_width_select == IBP_WIDTH_UART);
          state_next.smp = i_sample;
          state_next.st = IBP_UART;
        end
      end
      IBP_SPI: begin
        if (!state_reg.spi_valid || i_tx_ready) begin
          if (state_reg.spi_valid && state_reg.idx ==
              (state_reg.wide ? IBP_SPI_WORDS_32 : IBP_SPI_WORDS_16)) begin
            state_next.spi_valid = 1'b0;
            state_next.st = IBP_IDLE;
          end else begin
            state_next.spi_valid = 1'b1;
            state_next.spi_word = cur_word;
            state_next.idx = state_reg.idx + 6'h01;
          end
        end
      end
      IBP_UART: begin
        if (!state_reg.uart_valid || i_tx_ready) begin
          state_next.uart_valid = 1'b1;
          if (state_reg.idx == 6'h00) begin
            state_next.uart_byte = IBP_ADDR_BYTE;
            state_next.idx = 6'h01;
          end else if (state_reg.idx == IBP_UART_SLOTS + 6'h02) begin
            state_next.uart_valid = 1'b0;
            state_next.st = IBP_IDLE;
          end else if (state_reg.idx == IBP_UART_SLOTS + 6'h01) begin
            // slot IBP_UART_SLOTS is the checksum pair, so the delimiter follows it
            state_next.uart_byte = IBP_CR_BYTE;
            state_next.idx = state_reg.idx + 6'h01;
          end else begin
            state_next.uart_byte = state_reg.lo_byte ? cur_word[7:0] : cur_word[15:8];
            state_next.lo_byte = !state_reg.lo_byte;
            if (state_reg.lo_byte) begin
              state_next.idx = state_reg.idx + 6'h01;
            end
          end
        end
      end
      default: begin
        state_next.st = IBP_IDLE;
      end
    endcase
    // busy is registered so the output comes straight from a flop
    state_next.busy = (state_next.st != IBP_IDLE);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_spi_valid = state_reg.spi_valid;
  assign o_spi_word = state_reg.spi_word;
  assign o_uart_valid = state_reg.uart_valid;
  assign o_uart_byte = state_reg.uart_byte;
  assign o_busy = state_reg.busy;
  assign o_config_error = state_reg.cfg_err;

  // helper: counts words and bytes delivered in the current packet
  logic [6:0] sent_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_reg.st == IBP_IDLE) begin
      sent_reg <= 7'h00;
    end else if ((o_spi_valid || o_uart_valid) && i_tx_ready) begin
      sent_reg <= sent_reg + 7'h01;
    end
  end

  AST_SPI16_LEN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg.st == IBP_SPI && !state_reg.wide && state_next.st == IBP_IDLE)
    |=> sent_reg == 7'h0B) else $error("16-bit burst not 11 words");
  AST_SPI32_LEN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg.st == IBP_SPI && state_reg.wide && state_next.st == IBP_IDLE)
    |=> sent_reg == 7'h12) else $error("32-bit burst not 18 words");
  AST_UART_LEN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg.st == IBP_UART && state_next.st == IBP_IDLE)
    |=> sent_reg == 7'h2A) else $error("uart packet not 42 bytes");
  AST_UART_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_uart_valid && sent_reg == 7'h00) |-> o_uart_byte == IBP_ADDR_BYTE)
    else $error("uart packet missing address byte");
  AST_UART_CR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_uart_valid && sent_reg == 7'h29) |-> o_uart_byte == IBP_CR_BYTE)
    else $error("uart packet missing delimiter");
  AST_SPI_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_spi_valid && sent_reg == 7'h00) |-> o_spi_word == flag_word)
    else $error("burst does not start with flags");
  AST_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_uart_valid && !i_tx_ready) |=> $stable(o_uart_byte) && o_uart_valid)
    else $error("uart byte changed while stalled");
  AST_MSB_FIRST: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_uart_valid && i_tx_ready && sent_reg == 7'h03) |=> ##[0:8]
    (o_uart_valid && o_uart_byte == state_reg.smp.sensor[0][23:16]))
    else $error("temperature byte order wrong");

  COV_SPI16: cover property (@(posedge i_core_clk) i_spi_start && !o_busy &&
    i_burst_width_select == IBP_WIDTH_16);
  COV_SPI32: cover property (@(posedge i_core_clk) i_spi_start && !o_busy &&
    i_burst_width_select == IBP_WIDTH_32);
  COV_UART: cover property (@(posedge i_core_clk) o_uart_valid && o_uart_byte == IBP_CR_BYTE);
  COV_STALL: cover property (@(posedge i_core_clk) o_spi_valid && !i_tx_ready);
endmodule
`default_nettype wire

// >>> hw/ibp_pkg.sv
// shared constants and carriers for the burst packet formatter
package ibp_pkg;
  localparam logic [15:0] IBP_CONTENT_16 = 16'hF007;
  localparam logic [15:0] IBP_WIDTH_16 = 16'h0000;
  localparam logic [15:0] IBP_CONTENT_32 = 16'hF007;
  localparam logic [15:0] IBP_WIDTH_32 = 16'h7000;
  localparam logic [15:0] IBP_CONTENT_UART = 16'hF107;
  localparam logic [15:0] IBP_WIDTH_UART = 16'h7100;
  localparam logic [7:0] IBP_ADDR_BYTE = 8'h80;
  localparam logic [7:0] IBP_CR_BYTE = 8'h0D;
  localparam logic [5:0] IBP_SPI_WORDS_16 = 6'h0B;
  localparam logic [5:0] IBP_SPI_WORDS_32 = 6'h12;
  localparam logic [5:0] IBP_UART_SLOTS = 6'h14;
  localparam logic [4:0] IBP_NUM_FIELDS = 5'h0E;
  localparam logic [4:0] IBP_FLD_GPIO = 5'h09;
  localparam logic [4:0] IBP_FLD_COUNT = 5'h0A;
  localparam logic [4:0] IBP_FLD_CHECKSUM = 5'h0B;
  localparam logic [4:0] IBP_FLD_ANGLE = 5'h0C;

  typedef enum logic [1:0] {
    IBP_IDLE = 2'b00,
    IBP_SPI = 2'b01,
    IBP_UART = 2'b10
  } ibp_state_e;

  // one snapshot of a sample: fields 0..6 temp,rate xyz,accel xyz as 32 bits
  typedef struct packed {
    logic [7:0] new_data_flags;
    logic [7:0] error_flags;
    logic [6:0][31:0] sensor;
    logic [31:0] angle1;
    logic [15:0] gpio;
    logic [15:0] count;
    logic [15:0] checksum;
  } ibp_sample_s;
endpackage

// >>> sim/ibp_sink.sv
// host-side sink model: takes words and bytes, promptly or with random stalls
`timescale 1ns/1ps
`default_nettype none
module ibp_sink (
  input wire logic i_core_clk,
  input wire logic i_slow,
  output logic o_tx_ready
);
  initial o_tx_ready = 1'b0;
  // ready moves only just after an edge; slow mode accepts about one cycle in four
  // the sink only takes data and never issues reads mid-stream
  always @(posedge i_core_clk) begin
    o_tx_ready <= i_slow ? (($urandom & 3) == 0) : 1'b1;
  end
endmodule
`default_nettype wire

// >>> sim/test_imu_burst_packet_formatter.sv
// self-checking bench for the burst packet formatter
`timescale 1ns/1ps
`default_nettype none
module test_imu_burst_packet_formatter;
  import ibp_pkg::*;
  logic i_core_clk, i_rst_n, i_spi_start, i_uart_start, i_slow, i_tx_ready;
  logic i_range_over_flag, i_all_error_flag, o_spi_valid, o_uart_valid, o_busy, o_config_error;
  logic [15:0] i_burst_content_select, i_burst_width_select, o_spi_word;
  logic [6:0] i_sensor_new;
  logic [2:0] i_delta_rotation_new, i_delta_speed_new;
  logic [7:0] o_uart_byte;
  ibp_sample_s i_sample;
  logic [15:0] exp_w[$];
  logic [7:0] exp_b[$];
  int num_errors = 0;
  int checks = 0;

  ibp_formatter u_ibp_formatter (.i_core_clk, .i_rst_n, .i_burst_content_select,
    .i_burst_width_select, .i_spi_start, .i_uart_start, .i_sample, .i_sensor_new,
    .i_range_over_flag, .i_delta_rotation_new, .i_delta_speed_new, .i_all_error_flag,
    .i_tx_ready, .o_spi_valid, .o_spi_word, .o_uart_valid, .o_uart_byte, .o_busy,
    .o_config_error);
  ibp_sink u_ibp_sink (.i_core_clk, .i_slow, .o_tx_ready(i_tx_ready));

  // 250 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // scoreboard: each accepted word or byte takes the oldest note
  always @(posedge i_core_clk) begin
    if (i_rst_n && o_spi_valid === 1'b1 && i_tx_ready) begin
      if (exp_w.size() == 0) chk("spi extra word", 16'h0000, 16'hFFFF);
      else chk("spi word", exp_w.pop_front(), o_spi_word);
    end
    if (i_rst_n && o_uart_valid === 1'b1 && i_tx_ready) begin
      if (exp_b.size() == 0) chk("uart extra byte", 16'h0000, 16'hFFFF);
      else chk("uart byte", {8'h00, exp_b.pop_front()}, {8'h00, o_uart_byte});
    end
  end

  // one packet: random sample and flags held steady, notes queued before start
  task automatic pkt(bit uart, logic [15:0] c, logic [15:0] w, logic cfg);
    ibp_sample_s s;
    logic [6:0] sn;
    logic [2:0] dr, ds;
    logic ro, ae;
    logic [15:0] fw;
    logic [31:0] v;
    int n;
    for (n = 0; n < 10; n++) s[n*32+:32] = $urandom;
    sn = 7'($urandom);
    dr = 3'($urandom);
    ds = 3'($urandom);
    ro = 1'($urandom);
    ae = 1'($urandom);
    fw = {sn, ro, dr, ds, 1'b0, ae};
    if (uart) begin
      exp_b = {exp_b, 8'h80, fw[15:8], fw[7:0]};
      for (n = 0; n < 8; n++) begin
        v = (n < 7) ? s.sensor[n] : s.angle1;
        exp_b = {exp_b, v[31:24], v[23:16], v[15:8], v[7:0]};
      end
      exp_b = {exp_b, s.gpio[15:8], s.gpio[7:0], s.count[15:8], s.count[7:0]};
      exp_b = {exp_b, s.checksum[15:8], s.checksum[7:0], 8'h0D};
    end else begin
      exp_w.push_back(fw);
      for (n = 0; n < 7; n++) begin
        exp_w.push_back(s.sensor[n][31:16]);
        if (w == 16'h7000) exp_w.push_back(s.sensor[n][15:0]);
      end
      exp_w = {exp_w, s.gpio, s.count, s.checksum};
    end
    @(posedge i_core_clk);
    i_sample <= s;
    {i_sensor_new, i_range_over_flag, i_delta_rotation_new} <= {sn, ro, dr};
    {i_delta_speed_new, i_all_error_flag} <= {ds, ae};
    {i_burst_content_select, i_burst_width_select} <= {c, w};
    i_spi_start <= !uart;
    i_uart_start <= uart;
    @(posedge i_core_clk);
    {i_spi_start, i_uart_start} <= 2'b00;
    // a second start while busy must be ignored
    repeat (5) @(posedge i_core_clk);
    i_spi_start <= 1'b1;
    @(posedge i_core_clk);
    i_spi_start <= 1'b0;
    n = 0;
    while ((o_busy !== 1'b0 || exp_w.size() + exp_b.size() != 0) && n < 3000) begin
      @(posedge i_core_clk);
      n++;
    end
    @(posedge i_core_clk);
    chk("notes left", 16'h0000, 16'(exp_w.size() + exp_b.size()));
    chk("config error", {15'h0000, cfg}, {15'h0000, o_config_error});
    $display("test uart=%0d content %h width %h done", uart, c, w);
  endtask

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: a few packets with stalls need far fewer than 50000 cycles
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    {i_rst_n, i_spi_start, i_uart_start, i_slow} = 4'h0;
    {i_burst_content_select, i_burst_width_select} = 32'h0000_0000;
    i_sample = '0;
    {i_sensor_new, i_range_over_flag, i_delta_rotation_new} = 11'h000;
    {i_delta_speed_new, i_all_error_flag} = 4'h0;
    void'($urandom(32'h7DA5));
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    pkt(1'b0, 16'hF007, 16'h0000, 1'b0);
    pkt(1'b0, 16'hF007, 16'h7000, 1'b0);
    i_slow <= 1'b1;
    pkt(1'b1, 16'hF107, 16'h7100, 1'b0);
    pkt(1'b0, 16'h1234, 16'h7000, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
